// ---- core/cfg_bank.sv ----
// Upper configuration word bank (words 0x38 to 0x3F) of the strain-gauge front end,
// with Wishbone classic slave access and decode of every field to the consuming units.
// Assumes one 100 MHz clock, synchronous reset, and 10 kHz / 5 kHz ticks from the timer.
`timescale 1ns/1ps
`include "cfg_bank_defs.svh"
module cfg_bank #(
   parameter int                  LCD_W = 8
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   // Wishbone classic slave.
   input  wire logic              cyc_i,
   input  wire logic              stb_i,
   input  wire logic              we_i,
   input  wire logic [9:0]        adr_i,
   input  wire logic [3:0]        sel_i,
   input  wire logic [31:0]       dat_i,
   output logic      [31:0]       dat_o,
   output logic                   ack_o,
   // Arithmetic operands for the compensation unit.
   output logic signed [23:0]     span_temp_gain_o,
   output logic signed [23:0]     span_temp_offset_o,
   output logic signed [7:0]      supply_gain_factor_o,
   output logic      [7:0]        gain_correction_o,
   // GPIO control.
   output logic      [7:0]        io_input_buffer_on_o,
   output cfg_bank_pkg::pin_mode_t io_mode_o [8],
   output logic      [7:0]        io_output_o,
   output logic      [7:0]        io_pullup_o,
   output logic      [7:0]        io_pulldown_o,
   // Processor interrupt.
   input  wire logic              irq_pin3_i,
   input  wire logic              irq_pin4_i,
   input  wire logic              irq_done_i,
   output logic                   irq_event_o,
   output logic                   measure_hold_o,
   // LCD clock.
   input  wire logic              tick_10k_i,
   output logic                   lcd_clk_o,
   output logic                   lcd_clk_oe_o,
   output logic                   lcd_on_pin3_o,
   output logic                   lcd_on_pin4_o,
   // Comparator, supply, EEPROM and measurement control.
   output cfg_bank_pkg::comp_mode_t comp_mode_o,
   output logic      [1:0]        refresh_rate_o,
   output logic                   interference_suppress_on_o,
   output logic      [1:0]        epr_prg_time_o,
   output logic                   epr_erase_o,
   output logic                   epr_write_o,
   output logic                   store_conv_times_o,
   output logic      [1:0]        supply_measure_rate_o,
   // Pin function selects.
   output logic      [1:0]        pin3_function_choice_o,
   output logic      [3:0]        pin4_function_choice_o,
   output logic                   pin3_ext_irq_in_o,
   output logic                   pin4_ext_irq_in_o,
   // Multi-input ports.
   input  wire logic              tick_5k_i,
   output logic                   multi_input_base_clock_o,
   output logic      [1:0]        multi_input_rate_o,
   output logic      [2:0]        multi_input_port_on_o,
   output logic                   multi_input_tick_o,
   // Capacitive keys.
   output logic                   cap_adapt_on_o,
   output logic      [1:0]        cap_adapt_speed_o,
   output logic      [7:0]        cap_initial_threshold_o,
   output logic      [7:0]        touch_threshold_keys_low_o,
   output logic      [7:0]        touch_threshold_keys_high_o,
   output logic                   cap_rate_fast_o,
   output logic      [3:0]        cap_key_on_o,
   output logic      [1:0]        cap_discharge_r_o
);
   import cfg_bank_pkg::*;

   localparam int NWORDS = 8;
   logic [23:0] word [NWORDS];
   logic        irq_pin3_s1, irq_pin3_s2, irq_pin4_s1, irq_pin4_s2;
   logic        irq_src_q;
   logic        irq_pin3_q, irq_pin4_q;
   logic        mi_base_q;
   logic        hold;
   lcd_state_t  lcd_state;
   logic [LCD_W-1:0] lcd_cnt;
   logic        tick_q;
   logic [9:0]  mi_div;
   logic        ack;

   // Address decode: byte address is four times the word index.
   wire  [7:0]  idx      = adr_i[9:2];
   wire         req      = cyc_i & stb_i & ~ack;
   wire         in_bank  = (idx >= `IDX_SPAN_GAIN) && (idx <= `IDX_CAP_KEY);
   wire  [2:0]  widx     = idx[2:0];
   wire         wr_hit   = req & we_i & in_bank;
   wire  [23:0] bmask    = {{8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
   wire  [23:0] next_word = (word[widx] & ~bmask) | (dat_i[23:0] & bmask);
   wire  [23:0] status_w = {16'h0000, 2'b00, lcd_clk_o, hold, irq_src_q, multi_input_port_on_o};
   wire  [23:0] rd_word  = in_bank ? word[widx] :
                           (idx == `IDX_STATUS) ? status_w : `WORD_RESET;

   // Bus slave; ack lasts one cycle, reads of unmapped words return zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack   <= 1'b0;
         dat_o <= 32'h00000000;
      end else if (ce_i) begin
         ack   <= req;
         if (req) begin
            dat_o <= {8'h00, rd_word};
         end
      end
   end
   assign ack_o = ack;

   // Word storage: each word holds until rewritten.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < NWORDS; i++) begin
            word[i] <= `WORD_RESET;
         end
      end else if (ce_i && wr_hit) begin
         word[widx] <= next_word;
      end
   end

   // Arithmetic operands straight from the stored words.
   assign span_temp_gain_o     = word[0];
   assign span_temp_offset_o   = word[1];
   assign supply_gain_factor_o = word[2][`SUPPLY_GAIN_LSB +: 8];
   assign gain_correction_o    = word[2][`GAIN_COMP_LSB +: 8];

   // Pin mode decode, one entry per GPIO.
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         wire [1:0] m = word[3][`IO_MODE_LSB + 2*g +: 2];
         assign io_mode_o[g]            = pin_mode_t'(m);
         assign io_output_o[g]          = (m == PIN_OUT);
         assign io_pullup_o[g]          = (m == PIN_IN_PULLUP);
         assign io_pulldown_o[g]        = (m == PIN_IN_PULLDN);
         assign io_input_buffer_on_o[g] = word[3][`IO_DIG_EN_LSB + g];
      end
   endgenerate

   // Interrupt control fields.
   wire irq_pin_sel  = word[4][`IRQ_PIN_BIT];
   wire irq_neg      = word[4][`IRQ_EDGE_BIT];
   wire irq_en       = word[4][`IRQ_EN_BIT];
   wire irq_src      = irq_pin_sel ? irq_pin4_s2 : irq_pin3_s2;
   wire irq_edge     = irq_neg ? (irq_src_q & ~irq_src) : (~irq_src_q & irq_src);

   // Pin synchronisers and edge history; the pin may toggle asynchronously.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_pin3_s1 <= 1'b0;
         irq_pin3_s2 <= 1'b0;
         irq_pin4_s1 <= 1'b0;
         irq_pin4_s2 <= 1'b0;
         irq_pin3_q  <= 1'b0;
         irq_pin4_q  <= 1'b0;
      end else if (ce_i) begin
         irq_pin3_s1 <= irq_pin3_i;
         irq_pin3_s2 <= irq_pin3_s1;
         irq_pin4_s1 <= irq_pin4_i;
         irq_pin4_s2 <= irq_pin4_s1;
         irq_pin3_q  <= irq_pin3_s2;
         irq_pin4_q  <= irq_pin4_s2;
      end
   end
   // History is kept per pin, so a change of the pin select cannot fake an edge.
   assign irq_src_q   = irq_pin_sel ? irq_pin4_q : irq_pin3_q;
   assign irq_event_o = ce_i & irq_en & irq_edge;

   // Measurement hold: set by an enabled edge, released when service ends; set wins.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold <= 1'b0;
      end else if (ce_i) begin
         if (irq_en && irq_edge) begin
            hold <= 1'b1;
         end else if (irq_done_i || !irq_en) begin
            hold <= 1'b0;
         end
      end
   end
   assign measure_hold_o = hold;

   // LCD clock: a pulse on each edge of the 10 kHz tick gives double the rate.
   wire [1:0] lcd_sel = word[4][`LCD_SEL_LSB +: 2];
   wire       lcd_pol = word[4][`LCD_POL_BIT];
   wire       lcd_od  = word[4][`LCD_OD_BIT];
   wire       tick_edge = tick_10k_i ^ tick_q;
   wire [LCD_W-1:0] lcd_len = (lcd_sel == 2'd1) ? LCD_W'(`LCD_PW1_CYC) :
                              (lcd_sel == 2'd2) ? LCD_W'(`LCD_PW2_CYC) : LCD_W'(`LCD_PW3_CYC);

   // Pulse timer; each edge of the 10 kHz tick starts one pulse.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_q    <= 1'b0;
         lcd_state <= LCD_ST_IDLE;
         lcd_cnt   <= '0;
      end else if (ce_i) begin
         tick_q <= tick_10k_i;
         unique case (lcd_state)
            LCD_ST_IDLE: begin
               if (tick_edge && lcd_sel != 2'd0) begin
                  lcd_state <= LCD_ST_PULSE;
                  lcd_cnt   <= lcd_len - LCD_W'(1);
               end
            end
            LCD_ST_PULSE: begin
               if (lcd_cnt == '0) begin
                  lcd_state <= LCD_ST_IDLE;
               end else begin
                  lcd_cnt <= lcd_cnt - LCD_W'(1);
               end
            end
            default: lcd_state <= LCD_ST_IDLE;
         endcase
      end
   end

   // Pin drive: open drain only pulls the low level, whether idle or pulse; polarity sets the pulse level.
   wire lcd_active = (lcd_state == LCD_ST_PULSE);
   wire lcd_level  = lcd_active ? lcd_pol : ~lcd_pol;
   assign lcd_clk_o    = lcd_od ? 1'b0 : lcd_level;
   assign lcd_clk_oe_o = (lcd_sel != 2'd0) & (lcd_od ? ~lcd_level : 1'b1);

   // Pin function selects; input functions only apply when the pin is not an output.
   wire [1:0] fn3 = word[4][`PIN3_FN_LSB +: 2];
   wire [3:0] fn4 = word[5][`PIN4_FN_LSB +: 4];
   assign pin3_function_choice_o = fn3;
   assign pin4_function_choice_o = fn4;
   assign pin3_ext_irq_in_o = (io_mode_o[3] != PIN_OUT) & (fn3 == 2'd1);
   assign pin4_ext_irq_in_o = (io_mode_o[4] != PIN_OUT) & (fn4 == 4'd1);
   assign lcd_on_pin3_o = io_output_o[3] & (fn3 == 2'd3);
   assign lcd_on_pin4_o = io_output_o[4] & (fn4 == 4'd3);

   // Comparator, refresh, EEPROM and measurement control fields.
   assign comp_mode_o                = comp_mode_t'(word[4][`COMP_SW_LSB +: 2]);
   assign refresh_rate_o             = word[4][`REFRESH_LSB +: 2];
   assign interference_suppress_on_o = word[4][`EMI_BIT];
   assign epr_prg_time_o             = word[4][`EPR_TIME_LSB +: 2];
   assign epr_erase_o                = (epr_prg_time_o != 2'd3);
   assign epr_write_o                = (epr_prg_time_o != 2'd2);
   assign store_conv_times_o         = word[5][`STORE_TIME_BIT];
   assign supply_measure_rate_o      = word[6][`UPD_VLT_LSB +: 2];

   // Multi-input update tick: base tick divided by 800, 400, 200 or 100; 12.5 to 100 Hz on the 10 kHz base.
   wire       mi_base = word[5][`MI_BASE_BIT];
   wire [1:0] mi_rate = word[5][`MI_RATE_LSB +: 2];
   wire       mi_base_lvl  = mi_base ? tick_5k_i : tick_10k_i;
   wire       mi_base_tick = mi_base_lvl & ~mi_base_q;
   wire [9:0] mi_lim = (mi_rate == 2'd3) ? `MI_LIM_R3 : (mi_rate == 2'd2) ? `MI_LIM_R2 :
                       (mi_rate == 2'd1) ? `MI_LIM_R1 : `MI_LIM_R0;

   // Divider counts rising base edges: 100, 200, 400 or 800 of them per update.
   // A change of base clock may cost one stray count, which only shifts the phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mi_base_q <= 1'b0;
         mi_div    <= 10'h000;
      end else if (ce_i) begin
         mi_base_q <= mi_base_lvl;
         if (mi_base_tick) begin
            mi_div <= (mi_div >= mi_lim) ? 10'h000 : mi_div + 10'h001;
         end
      end
   end
   assign multi_input_base_clock_o = mi_base;
   assign multi_input_rate_o       = mi_rate;
   assign multi_input_port_on_o    = word[5][`MI_ON_LSB +: 3];
   assign multi_input_tick_o       = ce_i & mi_base_tick & (mi_div >= mi_lim) & (|multi_input_port_on_o);

   // Capacitive key word: layout depends on the adaption bit.
   wire cap_adapt = word[7][`CAP_ADAPT_BIT];
   assign cap_adapt_on_o              = cap_adapt;
   assign cap_adapt_speed_o           = cap_adapt ? word[7][`ADAPT_SPEED_LSB +: 2] : 2'd0;
   assign cap_initial_threshold_o     = cap_adapt ? word[7][`ADAPT_THR_LSB +: 8] : 8'h00;
   assign touch_threshold_keys_low_o  = cap_adapt ? 8'h00 : word[7][`THR_LOW_LSB +: 8];
   assign touch_threshold_keys_high_o = cap_adapt ? 8'h00 : word[7][`THR_HIGH_LSB +: 8];
   assign cap_rate_fast_o             = word[7][`CAP_RATE_BIT];
   assign cap_key_on_o                = word[7][`CAP_EN_LSB +: 4];
   assign cap_discharge_r_o           = word[7][`CAP_R_LSB +: 2];
endmodule

// ---- inc/cfg_bank_defs.svh ----
// Offsets, field positions and timing figures for the upper configuration word bank.
// Included by the package and the bank module; definitions only.
`ifndef CFG_BANK_DEFS_SVH
`define CFG_BANK_DEFS_SVH

// Word indices as printed; byte address is four times the index.
`define IDX_SPAN_GAIN        8'h38
`define IDX_SPAN_OFFSET      8'h39
`define IDX_SUPPLY_GAIN      8'h3A
`define IDX_GPIO_PORT        8'h3B
`define IDX_IRQ_DISPLAY      8'h3C
`define IDX_OSC_MULTI        8'h3D
`define IDX_SUPPLY_MEASURE   8'h3E
`define IDX_CAP_KEY          8'h3F
`define IDX_STATUS           8'h40
`define WORD_W               24
`define WORD_RESET           24'h000000

// Supply and gain correction word.
`define GAIN_COMP_LSB        0
`define SUPPLY_GAIN_LSB      8
// GPIO port word: two bits per pin from bit 0, enables from bit 16.
`define IO_MODE_LSB          0
`define IO_DIG_EN_LSB        16
// Interrupt / display / comparator word.
`define EPR_TIME_LSB         2
`define EMI_BIT              4
`define LCD_OD_BIT           5
`define REFRESH_LSB          8
`define LCD_SEL_LSB          10
`define PIN3_FN_LSB          12
`define IRQ_EN_BIT           14
`define IRQ_EDGE_BIT         15
`define COMP_SW_LSB          18
`define LCD_POL_BIT          22
`define IRQ_PIN_BIT          23
// Oscillator / multi-input word.
`define PIN4_FN_LSB          0
`define MI_ON_LSB            11
`define MI_RATE_LSB          14
`define MI_BASE_BIT          16
`define STORE_TIME_BIT       23
// Multi-input divider end counts, base edges per update less one, for rate codes 0 to 3.
`define MI_LIM_R0            10'h31F
`define MI_LIM_R1            10'h18F
`define MI_LIM_R2            10'h0C7
`define MI_LIM_R3            10'h063
// Supply measure word.
`define UPD_VLT_LSB          12
// Capacitive key word.
`define THR_LOW_LSB          0
`define THR_HIGH_LSB         8
`define ADAPT_SPEED_LSB      0
`define ADAPT_THR_LSB        8
`define CAP_R_LSB            16
`define CAP_EN_LSB           18
`define CAP_RATE_BIT         22
`define CAP_ADAPT_BIT        23

// LCD pulse widths in ns and the clock period in ns.
`define CLK_PERIOD_NS        10
`define LCD_PW1_NS           100
`define LCD_PW2_NS           200
`define LCD_PW3_NS           800
`define LCD_PW1_CYC          (`LCD_PW1_NS / `CLK_PERIOD_NS)
`define LCD_PW2_CYC          (`LCD_PW2_NS / `CLK_PERIOD_NS)
`define LCD_PW3_CYC          (`LCD_PW3_NS / `CLK_PERIOD_NS)
`endif

// ---- inc/cfg_bank_pkg.sv ----
// Types shared by the configuration bank and its consumers.
// Assumes cfg_bank_defs.svh is on the include path.
`include "cfg_bank_defs.svh"
package cfg_bank_pkg;
   typedef enum logic [1:0] {
      PIN_OUT       = 2'b00,
      PIN_IN_PULLUP = 2'b01,
      PIN_IN_PULLDN = 2'b10,
      PIN_IN_PLAIN  = 2'b11
   } pin_mode_t;
   typedef enum logic [1:0] {
      COMP_OFF      = 2'b00,
      COMP_MEASURE  = 2'b01,
      COMP_LOAD     = 2'b10,
      COMP_ALWAYS   = 2'b11
   } comp_mode_t;
   typedef enum logic [1:0] {
      LCD_ST_IDLE   = 2'b00,
      LCD_ST_PULSE  = 2'b01
   } lcd_state_t;
endpackage

// ---- tb/cfg_bank_checker.sv ----
// Concurrent checks on the ports of the configuration word bank.
// Assumes one clock domain with a synchronous active-high reset; bound to every bank.
`timescale 1ns/1ps
module cfg_bank_checker (
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   input wire logic                      ce_i,
   input wire logic                      cyc_i,
   input wire logic                      stb_i,
   input wire logic                      we_i,
   input wire logic [9:0]                adr_i,
   input wire logic [3:0]                sel_i,
   input wire logic [31:0]               dat_i,
   input wire logic [31:0]               dat_o,
   input wire logic                      ack_o,
   input wire logic signed [23:0]        span_temp_gain_o,
   input wire cfg_bank_pkg::pin_mode_t   io_mode_o [8],
   input wire logic [7:0]                io_output_o,
   input wire logic [7:0]                io_pullup_o,
   input wire logic [7:0]                io_pulldown_o,
   input wire logic                      irq_done_i,
   input wire logic                      irq_event_o,
   input wire logic                      measure_hold_o,
   input wire logic [1:0]                epr_prg_time_o,
   input wire logic                      epr_erase_o,
   input wire logic                      epr_write_o
);
   import cfg_bank_pkg::*;
   // All checks share the bank clock; reset masks them while it is held.
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_next;
      cyc_i && stb_i && ce_i && !ack_o |=> ack_o;
   endproperty
   a_ack_next: assert property (p_ack_next) else $error("ack did not follow a request");
   property p_ack_once;
      ack_o && ce_i |=> !ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");
   property p_idle_ack;
      !(cyc_i && stb_i) && ce_i |=> !ack_o;
   endproperty
   a_idle_ack: assert property (p_idle_ack) else $error("ack without a request");
   property p_store;
      cyc_i && stb_i && we_i && ce_i && !ack_o && adr_i == 10'h0E0 && sel_i[2:0] == 3'h7
         |=> span_temp_gain_o == $past(dat_i[23:0]);
   endproperty
   a_store: assert property (p_store) else $error("gain word not stored");
   property p_readback;
      ack_o && !we_i && adr_i == 10'h0E0 |-> dat_o == {8'h00, span_temp_gain_o};
   endproperty
   a_readback: assert property (p_readback) else $error("gain word read back wrong");
   property p_pin_decode;
      io_output_o[0] == (io_mode_o[0] == PIN_OUT) && io_pullup_o[7] == (io_mode_o[7] == PIN_IN_PULLUP)
         && io_pulldown_o[4] == (io_mode_o[4] == PIN_IN_PULLDN);
   endproperty
   a_pin_decode: assert property (p_pin_decode) else $error("pin mode decode wrong");
   property p_epr_modes;
      epr_erase_o == (epr_prg_time_o != 2'h3) && epr_write_o == (epr_prg_time_o != 2'h2);
   endproperty
   a_epr_modes: assert property (p_epr_modes) else $error("eeprom mode decode wrong");
   property p_hold_set;
      irq_event_o && ce_i |=> measure_hold_o;
   endproperty
   a_hold_set: assert property (p_hold_set) else $error("interrupt did not hold measurement");
   property p_hold_clear;
      measure_hold_o && irq_done_i && !irq_event_o && ce_i |=> !measure_hold_o;
   endproperty
   a_hold_clear: assert property (p_hold_clear) else $error("hold not released after service");
endmodule

bind cfg_bank cfg_bank_checker i_cfg_bank_checker (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
   .sel_i, .dat_i, .dat_o, .ack_o, .span_temp_gain_o, .io_mode_o, .io_output_o, .io_pullup_o,
   .io_pulldown_o, .irq_done_i, .irq_event_o, .measure_hold_o, .epr_prg_time_o, .epr_erase_o, .epr_write_o);

// ---- tb/tb_top.sv ----
// Self-checking bench for the upper configuration word bank.
// Assumes the bank, its package and the bound checker are compiled before this file.
`timescale 1ns/1ps
module tb_top;
   import cfg_bank_pkg::*;
   typedef struct packed {logic we; logic [9:0] adr; logic [23:0] wd; logic [31:0] ex;} row_t;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, irq_done_i = 1'b0;
   logic irq_pin3_i = 1'b0, irq_pin4_i = 1'b0;
   logic [9:0] adr_i = 10'h000;
   logic [8:0] tk = 9'h000;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [3:0] c;
   wire ce_i = 1'b1;
   wire [3:0] sel_i = 4'hF;
   wire tick_10k_i = tk[7];
   wire tick_5k_i = tk[8];
   logic signed [23:0] span_temp_gain_o, span_temp_offset_o;
   logic signed [7:0] supply_gain_factor_o;
   logic [7:0] gain_correction_o, io_input_buffer_on_o, io_output_o, io_pullup_o, io_pulldown_o;
   logic [7:0] cap_initial_threshold_o, touch_threshold_keys_low_o, touch_threshold_keys_high_o;
   pin_mode_t io_mode_o [8];
   comp_mode_t comp_mode_o;
   logic [1:0] refresh_rate_o, epr_prg_time_o, supply_measure_rate_o, pin3_function_choice_o;
   logic [1:0] multi_input_rate_o, cap_adapt_speed_o, cap_discharge_r_o;
   logic [3:0] pin4_function_choice_o, cap_key_on_o;
   logic [2:0] multi_input_port_on_o;
   logic ack_o, irq_event_o, measure_hold_o, lcd_clk_o, lcd_clk_oe_o, lcd_on_pin3_o, lcd_on_pin4_o;
   logic interference_suppress_on_o, epr_erase_o, epr_write_o, store_conv_times_o, pin3_ext_irq_in_o;
   logic pin4_ext_irq_in_o, multi_input_base_clock_o, multi_input_tick_o, cap_adapt_on_o, cap_rate_fast_o;
   int error_cnt = 0, cmp_count = 0, n, w_cnt;
   logic od = 1'b0;
   wire lcd_seen = od ? lcd_clk_oe_o : lcd_clk_o;
   // Writes, an unmapped write and read, and read-backs; read rows carry the expected data.
   row_t rows [9] = '{
      '{1'b1, 10'h0E0, 24'h123456, 32'h0}, '{1'b1, 10'h0E4, 24'hFEDCBA, 32'h0},
      '{1'b1, 10'h0E8, 24'h0080FF, 32'h0}, '{1'b1, 10'h0EC, 24'hA5E4E4, 32'h0},
      '{1'b1, 10'h000, 24'hABCDEF, 32'h0}, '{1'b0, 10'h000, 24'h0, 32'h0},
      '{1'b0, 10'h0E0, 24'h0, 32'h00123456}, '{1'b0, 10'h0E4, 24'h0, 32'h00FEDCBA},
      '{1'b0, 10'h0EC, 24'h0, 32'h00A5E4E4}};

   cfg_bank i_cfg_bank (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
      .span_temp_gain_o, .span_temp_offset_o, .supply_gain_factor_o, .gain_correction_o, .io_input_buffer_on_o,
      .io_mode_o, .io_output_o, .io_pullup_o, .io_pulldown_o, .irq_pin3_i, .irq_pin4_i, .irq_done_i,
      .irq_event_o, .measure_hold_o, .tick_10k_i, .lcd_clk_o, .lcd_clk_oe_o, .lcd_on_pin3_o, .lcd_on_pin4_o,
      .comp_mode_o, .refresh_rate_o, .interference_suppress_on_o, .epr_prg_time_o, .epr_erase_o, .epr_write_o,
      .store_conv_times_o, .supply_measure_rate_o, .pin3_function_choice_o, .pin4_function_choice_o,
      .pin3_ext_irq_in_o, .pin4_ext_irq_in_o, .tick_5k_i, .multi_input_base_clock_o, .multi_input_rate_o,
      .multi_input_port_on_o, .multi_input_tick_o, .cap_adapt_on_o, .cap_adapt_speed_o, .cap_initial_threshold_o,
      .touch_threshold_keys_low_o, .touch_threshold_keys_high_o, .cap_rate_fast_o, .cap_key_on_o,
      .cap_discharge_r_o);

   // Clock, and a tick divider that is much faster than the real base so the run stays short.
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i) tk <= tk + 9'h001;

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         error_cnt++;
      end
   endtask

   // One classic cycle; ack is sampled at rising edges, before the design's registers move there.
   task automatic wb(input logic w, input logic [9:0] a, input logic [23:0] d, output logic [31:0] rd);
      int k;
      k = 0;
      rd = 32'h0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {8'h00, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 20) begin
         error_cnt++;
         conclude();
      end else begin
         rd = dat_o;
         cyc_i <= 1'b0;
         stb_i <= 1'b0;
         we_i <= 1'b0;
      end
   endtask

   task automatic wait_hold(input logic lvl);
      int k;
      k = 0;
      while (measure_hold_o !== lvl && k < 30) begin
         @(negedge clk_i);
         k++;
      end
      chk(measure_hold_o, lvl);
   endtask

   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 10'h0E0, 24'h0, q);
      chk(q, 32'h0);
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].adr, rows[i].wd, q);
         if (!rows[i].we) chk(q, rows[i].ex);
      end
      chk({8'h00, span_temp_gain_o}, 32'h00123456);
      chk({8'h00, span_temp_offset_o}, 32'h00FEDCBA);
      chk({supply_gain_factor_o, gain_correction_o}, 32'h000080FF);
      chk({io_input_buffer_on_o, io_output_o, io_pullup_o, io_pulldown_o}, 32'hA5112244);
      wb(1'b1, 10'h100, 24'hFFFFFF, q);
      wb(1'b0, 10'h100, 24'h0, q);
      chk(q[31:6], 26'h0);
      // Every code of the comparator, refresh, pin 3 function and EEPROM time fields in the comparator and display word.
      for (int k = 0; k < 4; k++) begin
         c = k[3:0];
         wb(1'b1, 10'h0F0, {4'h0, c[1:0], 4'h0, c[1:0], 2'h0, c[1:0], 4'h0, c[1:0], 2'h0}, q);
         chk({comp_mode_o, refresh_rate_o, pin3_function_choice_o, epr_prg_time_o, epr_erase_o, epr_write_o,
              pin3_ext_irq_in_o, lcd_on_pin3_o},
             {c[1:0], c[1:0], c[1:0], c[1:0], c != 4'h3, c != 4'h2, c == 4'h1, 1'b0});
      end
      for (int k = 0; k < 16; k++) begin
         c = k[3:0];
         wb(1'b1, 10'h0F4, {c[0], 6'h0, c[0], c[1:0], c[2:0], 7'h0, c}, q);
         wb(1'b1, 10'h0F8, {10'h0, c[1:0], 12'h0}, q);
         chk({store_conv_times_o, multi_input_base_clock_o, multi_input_rate_o, multi_input_port_on_o,
              pin4_function_choice_o, supply_measure_rate_o, lcd_on_pin4_o, pin4_ext_irq_in_o},
             {c[0], c[0], c[1:0], c[2:0], c, c[1:0], c == 4'h3, 1'b0});
      end
      wb(1'b1, 10'h0FC, 24'h7F3456, q);
      chk({cap_adapt_on_o, cap_rate_fast_o, cap_key_on_o, cap_discharge_r_o, touch_threshold_keys_high_o,
           touch_threshold_keys_low_o}, 32'h007F3456);
      wb(1'b1, 10'h0FC, 24'h806403, q);
      chk({cap_adapt_on_o, cap_initial_threshold_o, cap_adapt_speed_o, touch_threshold_keys_high_o,
           touch_threshold_keys_low_o}, {1'b1, 8'h64, 2'h3, 16'h0});
      // Interrupt on pin 3 rising, then pin 4 falling; a wrong edge must not hold.
      wb(1'b1, 10'h0F0, 24'h004010, q);
      chk(interference_suppress_on_o, 1'b1);
      irq_pin3_i <= 1'b1;
      wait_hold(1'b1);
      @(posedge clk_i);
      irq_done_i <= 1'b1;
      @(posedge clk_i);
      irq_done_i <= 1'b0;
      wait_hold(1'b0);
      wb(1'b1, 10'h0F0, 24'h80C000, q);
      irq_pin4_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      chk(measure_hold_o, 1'b0);
      irq_pin4_i <= 1'b0;
      wait_hold(1'b1);
      // High pulses of each selectable width, then one open-drain low pulse seen on its enable.
      for (int k = 1; k < 5; k++) begin
         od = (k == 4);
         wb(1'b1, 10'h0F0, od ? 24'h000420 : 24'h400000 | (k << 10), q);
         n = 0;
         while (lcd_seen !== 1'b0 && n < 300) begin
            @(negedge clk_i);
            n++;
         end
         while (lcd_seen !== 1'b1 && n < 600) begin
            @(negedge clk_i);
            n++;
         end
         w_cnt = 0;
         while (lcd_seen === 1'b1 && w_cnt < 300) begin
            @(negedge clk_i);
            w_cnt++;
         end
         chk(w_cnt, (k == 1 || k == 4) ? 10 : (k == 2) ? 20 : 80);
         chk({lcd_clk_o, lcd_clk_oe_o}, {1'b0, !od});
      end
      // Fastest multi-input rate on the 10 kHz base: one update per 100 rising base edges.
      wb(1'b1, 10'h0F4, 24'h00C800, q);
      n = 0;
      while (multi_input_tick_o !== 1'b1 && n < 30000) begin
         @(negedge clk_i);
         n++;
      end
      w_cnt = 0;
      do begin
         @(negedge clk_i);
         w_cnt++;
      end while (multi_input_tick_o !== 1'b1 && w_cnt < 30000);
      chk(w_cnt, 256 * 100);
      // A second reset clears the words and the hold.
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 10'h0E0, 24'h0, q);
      chk(q, 32'h0);
      chk(measure_hold_o, 1'b0);
      conclude();
   end
endmodule
